/* File: dv/lfi_host_model.sv */
// Purpose: host side of the serial register link
// Assumes: 16 core cycles per link bit, msb first
// Notes:   mosi toggles between frames so stale data never look valid

`timescale 1ns/1ps

// ****************************************
// host link master
// ****************************************
module lfi_host_model (
  input  wire logic clock, // core clock
  input  wire logic miso,  // resolved data pin
  output logic      sck,   // link clock
  output logic      mosi,  // data to block
  output logic      ss_n   // select, low
);
  // link clock idles low between frames
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end

  // launch while low, sample at the rise
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (8) @(posedge clock);
      rx[i] = miso;
      sck <= 1'b1;
      repeat (8) @(posedge clock);
      sck <= 1'b0;
    end
  endtask

  // command, address, then n data bytes
  task automatic frame(input logic [7:0] c, a, input int n, input logic [63:0] wd, output logic [63:0] rd);
    logic [7:0] b;
    rd = '0;
    @(posedge clock);
    ss_n <= 1'b0;
    repeat (8) @(posedge clock);
    shift(c, b);
    shift(a, b);
    for (int k = n - 1; k >= 0; k--) begin
      shift(wd[8*k +: 8], b);
      rd[8*k +: 8] = b;
    end
    repeat (8) @(posedge clock);
    ss_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge clock);
  endtask
endmodule

/* File: dv/testbench.sv */
// Purpose: self-checking bench of the fault and interrupt block
// Assumes: faults and power-down are driven as plain levels
// Notes:   scroll pulses are driven for one cycle; released miso shows the inverse

`timescale 1ns/1ps

// ****************************************
// bench top
// ****************************************
`define CK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  logic clock, arst_n, power_down_n, sck, mosi, ss_n, miso, miso_oe_n, int_n, boost_run, mirror_run, clk_pin;
  logic [1:0] disp, clr, clr_seen, scroll;
  logic [3:0] lvl;
  logic [63:0] rd;
  lfi_pkg::lfi_fault_t faults;
  int fails, total_checks;
  wire miso_pin = miso_oe_n ? ~miso : miso; // released pin shows the inverse, stale data never pass
  lfi_fault_irq dut (.clock(clock), .arst_n(arst_n), .power_down_n(power_down_n), .sck(sck), .mosi(mosi),
    .ss_n(ss_n), .faults(faults), .scroll_step(scroll[0]), .scroll_done(scroll[1]), .clock_output_pin_src(1'b1), .miso(miso),
    .miso_oe_n(miso_oe_n), .int_n(int_n), .boost_run(boost_run), .mirror_run(mirror_run),
    .clock_output_pin(clk_pin), .display_select(disp), .boost_target_level(lvl), .pattern_clear(clr));
  lfi_host_model host (.clock(clock), .miso(miso_pin), .sck(sck), .mosi(mosi), .ss_n(ss_n));
  // sticky catch of the one-cycle clear pulses
  always @(posedge clock) clr_seen <= arst_n ? (clr_seen | clr) : 2'b00;

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // bounded wait for the interrupt level
  task automatic wait_int(input logic lv);
    for (int i = 0; i < 100 && int_n !== lv; i++) @(posedge clock);
    if (int_n !== lv) begin
      $display("BAD int_n exp %h got %h", lv, int_n);
      fails++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    host.frame(8'h00, a, 1, {56'h0, d}, rd);
  endtask

  task automatic t_reset;
    `CK("int_n", 1'b1, int_n)
    `CK("level", 4'hA, lvl)
    `CK("oe_n", 1'b1, miso_oe_n)
    wr(8'h40, 8'h01);
    wr(8'h16, 8'h8C);
    `CK("boost", 1'b1, boost_run)
    `CK("level", 4'hC, lvl)
    wr(8'h01, 8'h02);
    wr(8'h00, 8'h06);
    `CK("disp_clr", 4'hB, {disp, clr_seen})
    host.frame(8'h01, 8'h40, 3, 64'h0, rd);
    `CK("mask_latch_stat", 24'h010000, rd[23:0])
    $display("test registers done");
  endtask

  task automatic t_wrap;
    host.frame(8'h01, 8'hFF, 2, 64'h0, rd);
    `CK("ctrl_wrap", {4'h0, lfi_pkg::VERSION_ID, 8'h00}, rd[15:0])
    host.frame(8'h02, 8'hEF, 2, 64'hAA55, rd);
    host.frame(8'h03, 8'hEF, 2, 64'h0, rd);
    `CK("pat_wrap", 16'hAA55, rd[15:0])
    $display("test wrap done");
  endtask

  task automatic t_fault;
    @(posedge clock);
    faults.overvoltage <= 1'b1;
    faults.overheat <= 1'b1;
    wait_int(1'b0);
    repeat (4) @(posedge clock);
    `CK("boost_off", 1'b0, boost_run)
    `CK("mirror_off", 1'b0, mirror_run)
    host.frame(8'h01, 8'h41, 2, 64'h0, rd);
    `CK("latch_stat", 16'h0103, rd[15:0])
    `CK("int_clear", 1'b1, int_n)
    wr(8'h16, 8'h8A);
    `CK("hot_boost", 1'b0, boost_run)
    wr(8'h40, 8'h02);
    @(posedge clock);
    faults <= '0;
    wait_int(1'b0);
    host.frame(8'h01, 8'h41, 2, 64'h0, rd);
    `CK("cool_latch", 16'h0200, rd[15:0])
    `CK("no_restart", 1'b0, boost_run)
    $display("test faults done");
  endtask

  task automatic t_shut;
    power_down_n <= 1'b0;
    repeat (5) @(posedge clock);
    `CK("clk_low", 1'b0, clk_pin)
    `CK("miso_hiz", 1'b1, miso_oe_n)
    wr(8'h40, 8'hFF);
    host.frame(8'h01, 8'h40, 1, 64'h0, rd);
    `CK("miso_float", 8'hFD, rd[7:0])
    power_down_n <= 1'b1;
    repeat (5) @(posedge clock);
    `CK("clk_on", 1'b1, clk_pin)
    host.frame(8'h01, 8'h40, 1, 64'h0, rd);
    `CK("mask_kept", 8'h02, rd[7:0])
    $display("test shutdown done");
  endtask

  task automatic t_prot;
    wr(8'h40, 8'hFC);
    wr(8'h16, 8'h8A);
    wr(8'h00, 8'h01);
    `CK("run_on", 2'b11, {boost_run, mirror_run})
    faults.ref_open <= 1'b1;
    wait_int(1'b0);
    repeat (4) @(posedge clock);
    `CK("open_stop", 2'b10, {boost_run, mirror_run})
    wr(8'h10, 8'h10);
    `CK("int_ref", 1'b1, mirror_run)
    host.frame(8'h01, 8'h41, 2, 64'h0, rd);
    `CK("open_latch", 16'h0400, rd[15:0])
    faults.row_ground_fault <= 1'b1;
    faults.boost_good <= 1'b1;
    wait_int(1'b0);
    host.frame(8'h01, 8'h41, 2, 64'h0, rd);
    `CK("row_latch", 16'hC080, rd[15:0])
    host.frame(8'h01, 8'h00, 1, 64'h0, rd);
    `CK("row_en", 8'h00, rd[7:0])
    `CK("bst_keep", 2'b10, {boost_run, mirror_run})
    scroll <= 2'b11;
    @(posedge clock);
    scroll <= 2'b00;
    host.frame(8'h01, 8'h41, 1, 64'h0, rd);
    `CK("scroll_latch", 8'h30, rd[7:0])
    faults.uvlo <= 1'b1;
    faults.row_ground_fault <= 1'b0;
    repeat (4) @(posedge clock);
    `CK("uvlo_off", 2'b00, {boost_run, mirror_run})
    faults.uvlo <= 1'b0;
    repeat (4) @(posedge clock);
    host.frame(8'h02, 8'h00, 1, 64'h5A, rd);
    wr(8'h00, 8'h01);
    `CK("run_again", 2'b11, {boost_run, mirror_run})
    $display("test protection done");
  endtask

  initial begin
    arst_n = 1'b0;
    power_down_n = 1'b1;
    faults = '0;
    scroll = 2'b00;
    fails = 0;
    total_checks = 0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_wrap();
    t_fault();
    t_shut();
    t_prot();
    complete_run();
  end
endmodule

/* File: src/lfi_fault_irq.sv */
// Purpose: protection, interrupt latch and serial register access of the display driver
// Assumes: fault inputs and power_down_n are asynchronous; scroll pulses are on clock
// Notes:   pattern bytes live in lfi_pattern_ram, bit timing in lfi_spi_link
//
// Summary of operation
// - control addresses 00..FF valid; pattern writes above EF are dropped
// - pointer steps by one per byte written or read
// - pointer wraps to zero past the last address of its memory
// - link clock idles low; sample on rise, launch on fall
// - bytes after the first in a frame go to consecutive addresses
// - mask bits from 0: ov, heat, open, short, step, done, row, boost ok
// - latch bits set on events and clear only by reading the latch
// - no latch bit sets while its mask bit is zero
// - status shows live ov, heat, open, short and boost-ok conditions, not row short or undervoltage; reads change nothing
// - overvoltage stops boost, sets status, latches event if enabled
// - overheat clears enable and boost enable, latches event if enabled
// - cooling clears heat status, latches again, no automatic restart
// - while overheated, boost and mirrors stay off whatever software writes
// - open reference with external source stops mirrors only, latches event
// - shorted reference with external source stops mirrors only, latches event
// - row short stops mirrors, clears enable, latches event if enabled
// - boost-ok status follows target; each change latches; no power effect
// - power-down low keeps shutdown and rejects all register writes
// - shutdown floats serial data out and drives clock output low
// - undervoltage turns off boost and column drivers, regulator stays
// - scroll done and scroll step pulses feed their latch bits
// - first byte is command: even write, odd read; ctrl, pattern1, pattern2

`timescale 1ns/1ps

// ****************************************
// top
// ****************************************
module lfi_fault_irq (
  input  wire logic               clock,            // core clock 200 MHz
  input  wire logic               arst_n,           // async reset, low
  input  wire logic               power_down_n,     // shutdown pin, low
  input  wire logic               sck,              // link clock pin
  input  wire logic               mosi,             // serial data in
  input  wire logic               ss_n,             // select, low
  input  wire lfi_pkg::lfi_fault_t faults,          // live fault levels
  input  wire logic               scroll_step,      // step pulse
  input  wire logic               scroll_done,      // scroll end pulse
  input  wire logic               clock_output_pin_src,       // clock to forward
  output logic                    miso,             // serial data out
  output logic                    miso_oe_n,        // miso enable, low
  output logic                    int_n,            // interrupt, low
  output logic                    boost_run,        // boost converter on
  output logic                    mirror_run,       // mirrors and columns on
  output logic                    clock_output_pin, // forwarded clock
  output logic [1:0]              display_select,   // shown pattern
  output logic [3:0]              boost_target_level, // boost setpoint
  output logic [1:0]              pattern_clear     // clear pulses
);

  // ****************************************
  // synchronisers and edges
  // ****************************************
  lfi_pkg::lfi_fault_t f_m, f_s, f_d;
  logic pd_m, pd_s, open_d, short_d;

  // two flops before any logic looks at a fault or power-down pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      f_m  <= '0;
      f_s  <= '0;
      f_d  <= '0;
      pd_m <= 1'b0;
      pd_s <= 1'b0;
    end else begin
      f_m  <= faults;
      f_s  <= f_m;
      f_d  <= f_s;
      pd_m <= power_down_n;
      pd_s <= pd_m;
    end
  end

  // ****************************************
  // registers and link state
  // ****************************************
  logic              en_reg, en_next, internal_reference_select_reg, internal_reference_select_next;
  logic              boost_on_reg, boost_on_next;
  logic [1:0]        disp_reg, disp_next;
  logic [3:0]        vout_reg, vout_next;
  logic [7:0]        mask_reg, mask_next, latch_reg, latch_next;
  logic [7:0]        ptr_reg, ptr_next, ctrl_rd_reg, mem_rdata;
  logic [1:0]        sel_reg, sel_next, clr_reg, clr_next;
  logic              rd_reg, rd_next;
  lfi_pkg::lfi_phase_t ph_reg, ph_next;
  lfi_pkg::lfi_rx_t  rx;
  logic              tx_taken, frame_on;

  // ****************************************
  // decode
  // ****************************************
  // wrap point of the selected memory
  function automatic logic [7:0] limit_of(input logic [1:0] sel);
    limit_of = (sel == lfi_pkg::SEL_CTRL) ? lfi_pkg::LIMIT_CTRL : lfi_pkg::LIMIT_PATTERN;
  endfunction

  // command byte: bit 0 read, bits 2:1 memory
  function automatic logic [1:0] sel_of(input logic [7:0] cmd);
    sel_of = (cmd[7:3] != 5'd0 || cmd[2:1] == 2'd3) ? lfi_pkg::SEL_NONE : cmd[2:1];
  endfunction

  wire pwr_on    = pd_s;
  wire in_data   = (ph_reg == lfi_pkg::PH_DATA);
  wire wr_byte   = rx.valid && in_data && !rd_reg;
  wire byte_step = wr_byte || tx_taken;
  wire at_limit  = (ptr_reg >= limit_of(sel_reg));
  // writes beyond the pattern range and in shutdown are dropped
  wire wr_ok     = wr_byte && pwr_on && (ptr_reg <= limit_of(sel_reg));
  wire reg_we    = wr_ok && (sel_reg == lfi_pkg::SEL_CTRL);
  wire mem_we    = wr_ok && (sel_reg == lfi_pkg::SEL_PAT1 || sel_reg == lfi_pkg::SEL_PAT2);
  wire [8:0] mem_addr = {sel_reg[1], ptr_reg};
  wire tx_arm    = in_data && rd_reg;
  wire [7:0] tx_byte = (sel_reg == lfi_pkg::SEL_CTRL) ? ctrl_rd_reg :
                       (sel_reg == lfi_pkg::SEL_NONE) ? 8'h00 : mem_rdata;
  wire [7:0] wdata   = rx.data;

  // reference faults count only with device on and external reference
  wire open_q  = f_s.ref_open & en_reg & ~internal_reference_select_reg;
  wire short_q = f_s.ref_short & en_reg & ~internal_reference_select_reg;

  // events in mask bit order
  wire [7:0] events = {f_s.boost_good ^ f_d.boost_good,
                       f_s.row_ground_fault & ~f_d.row_ground_fault,
                       scroll_done,
                       scroll_step,
                       short_q & ~short_d,
                       open_q & ~open_d,
                       f_s.overheat ^ f_d.overheat,
                       f_s.overvoltage & ~f_d.overvoltage};
  // live status, no read side effect
  wire [7:0] status = {f_s.boost_good, 3'b000, short_q, open_q, f_s.overheat, f_s.overvoltage};
  // only the bits actually delivered are cleared
  wire [7:0] latch_clr = (tx_taken && sel_reg == lfi_pkg::SEL_CTRL && ptr_reg == lfi_pkg::ADDR_LATCH)
                         ? tx_byte : 8'h00;
  wire soft_rst = reg_we && ptr_reg == lfi_pkg::ADDR_SW_CTRL && wdata[lfi_pkg::BIT_SOFT_RESET];

  // read mux of the control space
  function automatic logic [7:0] ctrl_rd(input logic [7:0] a, input logic [7:0] st,
                                         input logic [7:0] lt, input logic [7:0] mk);
    case (a)
      lfi_pkg::ADDR_SW_CTRL: ctrl_rd = {7'h00, en_reg};
      lfi_pkg::ADDR_DISPLAY: ctrl_rd = {6'h00, disp_reg};
      lfi_pkg::ADDR_CLOCK:   ctrl_rd = {3'h0, internal_reference_select_reg, 4'h0};
      lfi_pkg::ADDR_BOOST:   ctrl_rd = {boost_on_reg, 3'h0, vout_reg};
      lfi_pkg::ADDR_MASK:    ctrl_rd = mk;
      lfi_pkg::ADDR_LATCH:   ctrl_rd = lt;
      lfi_pkg::ADDR_STATUS:  ctrl_rd = st;
      lfi_pkg::ADDR_VERSION: ctrl_rd = {4'h0, lfi_pkg::VERSION_ID};
      default:               ctrl_rd = 8'h00;
    endcase
  endfunction

  // ****************************************
  // frame sequencing
  // ****************************************
  // command, address, then data bytes to consecutive addresses
  always_comb begin
    ph_next  = ph_reg;
    sel_next = sel_reg;
    rd_next  = rd_reg;
    ptr_next = ptr_reg;
    if (!frame_on) begin
      ph_next = lfi_pkg::PH_CMD;
    end else begin
      case (ph_reg)
        lfi_pkg::PH_CMD: begin
          if (rx.valid) begin
            sel_next = sel_of(rx.data);
            rd_next  = rx.data[0];
            ph_next  = lfi_pkg::PH_ADDR;
          end
        end
        lfi_pkg::PH_ADDR: begin
          if (rx.valid) begin
            ptr_next = rx.data;
            ph_next  = lfi_pkg::PH_DATA;
          end
        end
        lfi_pkg::PH_DATA: begin
          if (byte_step) begin
            ptr_next = at_limit ? 8'h00 : ptr_reg + 8'h01;
          end
        end
        default: ph_next = lfi_pkg::PH_CMD;
      endcase
    end
  end

  // ****************************************
  // register writes and hardware actions
  // ****************************************
  always_comb begin
    en_next       = en_reg;
    disp_next     = disp_reg;
    internal_reference_select_next   = internal_reference_select_reg;
    boost_on_next = boost_on_reg;
    vout_next     = vout_reg;
    mask_next     = mask_reg;
    clr_next      = 2'b00;
    if (soft_rst) begin
      en_next       = lfi_pkg::RST_SW_CTRL[lfi_pkg::BIT_EN];
      disp_next     = lfi_pkg::RST_DISPLAY;
      internal_reference_select_next   = 1'b0;
      boost_on_next = 1'b0;
      vout_next     = lfi_pkg::RST_VOUT;
      mask_next     = lfi_pkg::RST_MASK;
    end else if (reg_we) begin
      case (ptr_reg)
        lfi_pkg::ADDR_SW_CTRL: begin
          en_next  = wdata[lfi_pkg::BIT_EN];
          clr_next = {wdata[lfi_pkg::BIT_SECOND_PATTERN_CLEAR], wdata[lfi_pkg::BIT_FIRST_PATTERN_CLEAR]};
        end
        lfi_pkg::ADDR_DISPLAY: disp_next   = wdata[1:0];
        lfi_pkg::ADDR_CLOCK:   internal_reference_select_next = wdata[lfi_pkg::BIT_INTERNAL_REFERENCE_SELECT];
        lfi_pkg::ADDR_BOOST: begin
          boost_on_next = wdata[lfi_pkg::BIT_BOOST_ON];
          vout_next     = wdata[3:0];
        end
        lfi_pkg::ADDR_MASK:    mask_next   = wdata;
        default:               mask_next   = mask_reg;
      endcase
    end
    // hardware clears win over a same-cycle write; no automatic restart
    if (f_s.overvoltage & ~f_d.overvoltage) boost_on_next = 1'b0;
    // held while hot so a write made during overheat cannot restart anything on cooling
    if (f_s.overheat) begin
      en_next       = 1'b0;
      boost_on_next = 1'b0;
    end
    if (f_s.row_ground_fault & ~f_d.row_ground_fault) en_next = 1'b0;
    // set wins over read clear
    latch_next = (latch_reg & ~latch_clr) | (events & mask_reg);
  end

  // state flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg       <= lfi_pkg::PH_CMD;
      sel_reg      <= lfi_pkg::SEL_CTRL;
      rd_reg       <= 1'b0;
      ptr_reg      <= 8'h00;
      en_reg       <= lfi_pkg::RST_SW_CTRL[lfi_pkg::BIT_EN];
      disp_reg     <= lfi_pkg::RST_DISPLAY;
      internal_reference_select_reg   <= 1'b0;
      boost_on_reg <= 1'b0;
      vout_reg     <= lfi_pkg::RST_VOUT;
      mask_reg     <= lfi_pkg::RST_MASK;
      latch_reg    <= lfi_pkg::RST_LATCH;
      clr_reg      <= 2'b00;
      open_d       <= 1'b0;
      short_d      <= 1'b0;
      ctrl_rd_reg  <= 8'h00;
    end else begin
      ph_reg       <= ph_next;
      sel_reg      <= sel_next;
      rd_reg       <= rd_next;
      ptr_reg      <= ptr_next;
      en_reg       <= en_next;
      disp_reg     <= disp_next;
      internal_reference_select_reg   <= internal_reference_select_next;
      boost_on_reg <= boost_on_next;
      vout_reg     <= vout_next;
      mask_reg     <= mask_next;
      latch_reg    <= latch_next;
      clr_reg      <= clr_next;
      open_d       <= open_q;
      short_d      <= short_q;
      ctrl_rd_reg  <= ctrl_rd(ptr_reg, status, latch_reg, mask_reg);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // overheat, faults and undervoltage gate the power stages
  // interrupt follows latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      int_n              <= 1'b1;
      boost_run          <= 1'b0;
      mirror_run         <= 1'b0;
      clock_output_pin   <= 1'b0;
      display_select     <= lfi_pkg::RST_DISPLAY;
      boost_target_level <= lfi_pkg::RST_VOUT;
      pattern_clear      <= 2'b00;
    end else begin
      int_n              <= ~|latch_next;
      boost_run          <= pwr_on & boost_on_reg & ~f_s.overheat & ~f_s.overvoltage & ~f_s.uvlo;
      mirror_run         <= pwr_on & en_reg & ~f_s.overheat & ~open_q & ~short_q
                            & ~f_s.row_ground_fault & ~f_s.uvlo;
      clock_output_pin   <= pwr_on & clock_output_pin_src;
      display_select     <= disp_reg;
      boost_target_level <= vout_reg;
      pattern_clear      <= clr_reg;
    end
  end

  // ****************************************
  // submodules
  // ****************************************
  lfi_spi_link u_link (
    .clock     (clock),
    .arst_n    (arst_n),
    .sck       (sck),
    .mosi      (mosi),
    .ss_n      (ss_n),
    .shutdown  (~pwr_on),
    .tx_arm    (tx_arm),
    .tx_byte   (tx_byte),
    .rx        (rx),
    .tx_taken  (tx_taken),
    .frame_on  (frame_on),
    .miso      (miso),
    .miso_oe_n (miso_oe_n)
  );

  lfi_pattern_ram u_ram (
    .clock  (clock),
    .arst_n (arst_n),
    .we     (mem_we),
    .waddr  (mem_addr),
    .wdata  (wdata),
    .raddr  (mem_addr),
    .rdata  (mem_rdata)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_latch_masked : assert property (((latch_reg & ~$past(latch_reg)) & ~$past(mask_reg)) == 8'h00)
    else $error("latch bit set while masked");
  a_latch_sticky : assert property (|($past(latch_reg) & ~latch_reg) |-> $past(tx_taken, 1))
    else $error("latch bit cleared without read");
  a_heat_blocks : assert property (f_s.overheat |=> !boost_run && !mirror_run)
    else $error("power stage on while overheated");
  a_int_follows : assert property ((|latch_reg) |-> !int_n)
    else $error("interrupt missing with latch set");
  a_no_write_off : assert property (!pwr_on |-> !mem_we && !reg_we)
    else $error("write accepted in shutdown");
  a_ptr_wrap : assert property (in_data && byte_step && at_limit && frame_on |=> ptr_reg == 8'h00)
    else $error("pointer did not wrap");
  a_ptr_step : assert property (in_data && byte_step && !at_limit && frame_on
    |=> ptr_reg == $past(ptr_reg) + 8'h01) else $error("pointer did not advance");
  a_uvlo_off : assert property (f_s.uvlo |=> !boost_run && !mirror_run)
    else $error("drivers on in undervoltage");
  a_row_clears_en : assert property ($rose(f_s.row_ground_fault) |=> !en_reg)
    else $error("enable kept after row short");
  a_clock_output_pin_low : assert property (!pwr_on |=> !clock_output_pin)
    else $error("clock output driven in shutdown");

endmodule

/* File: src/lfi_pattern_ram.sv */
// Purpose: byte store for both display patterns
// Assumes: one write port, one read port, same clock
// Notes:   array has no reset; read data come from a register

`timescale 1ns/1ps

// ****************************************
// pattern store
// ****************************************
module lfi_pattern_ram (
  input  wire logic       clock,  // core clock
  input  wire logic       arst_n, // async reset, low
  input  wire logic       we,     // write strobe
  input  wire logic [8:0] waddr,  // pattern bit + byte address
  input  wire logic [7:0] wdata,  // write byte
  input  wire logic [8:0] raddr,  // read address
  output logic      [7:0] rdata   // registered read byte
);

  logic [7:0] mem [0:511];

  // write port
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

/* File: src/lfi_pkg.sv */
// Purpose: shared constants and types for the fault/interrupt block and its serial register port
// Assumes: one 200 MHz core clock; serial link sampled by that clock
// Notes:   offsets are byte addresses inside the control register space

// ****************************************
// package
// ****************************************
package lfi_pkg;

  // register offsets
  localparam logic [7:0] ADDR_SW_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_DISPLAY  = 8'h01;
  localparam logic [7:0] ADDR_CLOCK    = 8'h10;
  localparam logic [7:0] ADDR_BOOST    = 8'h16;
  localparam logic [7:0] ADDR_MASK     = 8'h40;
  localparam logic [7:0] ADDR_LATCH    = 8'h41;
  localparam logic [7:0] ADDR_STATUS   = 8'h42;
  localparam logic [7:0] ADDR_VERSION  = 8'hFF;

  // last valid address of each memory
  localparam logic [7:0] LIMIT_CTRL    = 8'hFF;
  localparam logic [7:0] LIMIT_PATTERN = 8'hEF;

  // field positions
  localparam int BIT_EN          = 0;
  localparam int BIT_FIRST_PATTERN_CLEAR        = 1;
  localparam int BIT_SECOND_PATTERN_CLEAR        = 2;
  localparam int BIT_SOFT_RESET  = 7;
  localparam int BIT_INTERNAL_REFERENCE_SELECT      = 4;
  localparam int BIT_BOOST_ON    = 7;
  localparam int BIT_STEP        = 4;
  localparam int BIT_DONE        = 5;

  // values after reset
  localparam logic [7:0] RST_SW_CTRL = 8'h00;
  localparam logic [1:0] RST_DISPLAY = 2'h0;
  localparam logic [3:0] RST_VOUT    = 4'hA;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_LATCH   = 8'h00;

  // version code; value is arbitrary
  localparam logic [3:0] VERSION_ID  = 4'h3;

  // memory selected by the command byte
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_PAT1 = 2'h1;
  localparam logic [1:0] SEL_PAT2 = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // frame phases, gray coded
  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b11
  } lfi_phase_t;

  // live fault conditions from the analog side
  typedef struct packed {
    logic uvlo;
    logic boost_good;
    logic row_ground_fault;
    logic ref_short;
    logic ref_open;
    logic overheat;
    logic overvoltage;
  } lfi_fault_t;

  // one received byte
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } lfi_rx_t;

endpackage

/* File: src/lfi_spi_link.sv */
// Purpose: serial link bit engine, sampled by the core clock
// Assumes: link clock idles low and runs far below the core clock
// Notes:   miso launch needs tx_byte stable three cycles after rx pulse

`timescale 1ns/1ps

// ****************************************
// link engine
// ****************************************
module lfi_spi_link (
  input  wire logic       clock,     // core clock
  input  wire logic       arst_n,    // async reset, low
  input  wire logic       sck,       // link clock pin
  input  wire logic       mosi,      // serial data in pin
  input  wire logic       ss_n,      // select pin, low
  input  wire logic       shutdown,  // power down level
  input  wire logic       tx_arm,    // read data wanted
  input  wire logic [7:0] tx_byte,   // byte to launch
  output lfi_pkg::lfi_rx_t rx,       // received byte pulse
  output logic            tx_taken,  // tx_byte loaded
  output logic            frame_on,  // select active
  output logic            miso,      // serial data out
  output logic            miso_oe_n  // output enable, low
);

  logic       sck_m, sck_s, sck_d, mosi_m, mosi_s, ss_m, ss_s;
  logic [2:0] bit_reg;
  logic [7:0] rsh_reg, tsh_reg;
  wire        rise = sck_s & ~sck_d & ~ss_s;
  wire        fall = ~sck_s & sck_d & ~ss_s;
  wire        load = fall && (bit_reg == 3'd0) && tx_arm;

  // two flops on every pin before use
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {sck_m, sck_s, sck_d, mosi_m, mosi_s} <= 5'h00;
      {ss_m, ss_s}                          <= 2'h3;
    end else begin
      {sck_m, sck_s, sck_d} <= {sck, sck_m, sck_s};
      {mosi_m, mosi_s}      <= {mosi, mosi_m};
      {ss_m, ss_s}          <= {ss_n, ss_m};
    end
  end

  // sample on rising edge, msb first
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bit_reg <= 3'd0;
      rsh_reg <= 8'h00;
      rx      <= '0;
    end else begin
      rx.valid <= 1'b0;
      if (ss_s) begin
        bit_reg <= 3'd0;
      end else if (rise) begin
        rsh_reg  <= {rsh_reg[6:0], mosi_s};
        bit_reg  <= bit_reg + 3'd1;
        rx.valid <= (bit_reg == 3'd7);
        rx.data  <= {rsh_reg[6:0], mosi_s};
      end
    end
  end

  // launch on falling edge; tri-state in shutdown
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tsh_reg   <= 8'h00;
      miso      <= 1'b0;
      tx_taken  <= 1'b0;
      frame_on  <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      tx_taken  <= load;
      frame_on  <= ~ss_s;
      miso_oe_n <= ss_s | shutdown;
      if (load) begin
        miso    <= tx_byte[7];
        tsh_reg <= {tx_byte[6:0], 1'b0};
      end else if (fall) begin
        miso    <= tsh_reg[7];
        tsh_reg <= {tsh_reg[6:0], 1'b0};
      end
    end
  end

  // no output while powered down
  a_miso_shutdown : assert property (@(posedge clock) disable iff (!arst_n)
    shutdown |=> miso_oe_n) else $error("miso driven in shutdown");

endmodule
